// ===== rtl/sls_pkg.sv
// Shared constants for the serial LED switch shifter link
package sls_pkg;
  localparam int CHANNELS = 12;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_PERIOD_MIN_NS = 1000;
  localparam int SCK_PHASE_MIN_NS = 480;
  localparam int DATA_HOLD_MIN_NS = 980;
  localparam int LATCH_HIGH_MIN_NS = 480;
  localparam int LATCH_DELAY_MIN_NS = 250;
  // Half period covers both the phase minimum and half the period minimum
  localparam int SCK_HALF_NS = (SCK_PERIOD_MIN_NS / 2 > SCK_PHASE_MIN_NS) ? SCK_PERIOD_MIN_NS / 2 : SCK_PHASE_MIN_NS;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_HIGH_CYC = (LATCH_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_DELAY_CYC = (LATCH_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam int BITS_W = 8;
  localparam logic [0:0] OE_DRIVE = 1'h0;
  localparam logic [0:0] OE_RELEASE = 1'h1;
endpackage

// ===== rtl/sls_link_if.sv
// Three-wire serial link plus reset and disable between host and switch
`timescale 1ns/1ps
interface sls_link_if;
  logic sck;
  logic sdata;
  logic latch;
  logic reset_n;
  logic output_disable;
  logic cascade_data_out;
  modport host (
    output sck,
    output sdata,
    output latch,
    output reset_n,
    output output_disable,
    input  cascade_data_out
  );
  modport device (
    input  sck,
    input  sdata,
    input  latch,
    input  reset_n,
    input  output_disable,
    output cascade_data_out
  );
endinterface

// ===== rtl/sls_device.sv
// Switch end: shift register, holding register and gated open-drain outputs
//
// Operation
// - Shift register followed by latched holding register
// - Reset low clears registers, outputs open
// - Host keeps reset low during power-up
// - Rising clock shifts data into 12 bits
// - Rising latch copies shift into holding
// - Holding keeps value until next latch
// - Frame MSB first; one means on
// - Disable high forces all outputs open
// - Disable high suspends over-temperature cutoff
// - Disable waveform modulates enabled outputs
// - Cascade output changes on falling clock
// - Two chained devices need 24 bits
// - Clock period and phases held minimum
// - Each data bit held minimum time
// - Latch high held minimum time
// - Latch rises after last clock delay
// - Over-temperature forces outputs off, auto-resumes
`timescale 1ns/1ps
module sls_device #(
  parameter int WIDTH = sls_pkg::CHANNELS
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  sls_link_if.device            link,
  input  wire logic             over_temperature_cutoff,
  output logic [WIDTH-1:0]      drive_outputs_oe,
  output logic [WIDTH-1:0]      drive_outputs,
  output logic [WIDTH-1:0]      holding_state
);
  // Stage 0 takes the pin; stages 1 and 2 vote on a change
  logic [2:0]       sck_sync;
  logic [2:0]       sdata_sync;
  logic [2:0]       latch_sync;
  logic [2:0]       rstn_sync;
  logic [2:0]       dis_sync;
  logic [2:0]       hot_sync;
  logic             sck_level;
  logic             sdata_level;
  logic             latch_level;
  logic             rstn_level;
  logic             dis_level;
  logic             hot_level;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] hold_reg;
  logic             cascade_bit;

  // Level a filtered pin takes at the next edge
  function automatic logic filter_next(input logic [2:0] stages, input logic level);
    filter_next = (stages[1] == stages[2]) ? stages[2] : level;
  endfunction

  // Low to high step between two filtered levels
  function automatic logic went_high(input logic was_level, input logic now_level);
    went_high = now_level & ~was_level;
  endfunction

  // Three flip-flops on every pin from outside this clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_sync <= '0;
    end else begin
      sck_sync <= {sck_sync[1:0], link.sck};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdata_sync <= '0;
    end else begin
      sdata_sync <= {sdata_sync[1:0], link.sdata};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_sync <= '0;
    end else begin
      latch_sync <= {latch_sync[1:0], link.latch};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstn_sync <= '0;
    end else begin
      rstn_sync <= {rstn_sync[1:0], link.reset_n};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dis_sync <= 3'h7;
    end else begin
      dis_sync <= {dis_sync[1:0], link.output_disable};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hot_sync <= '0;
    end else begin
      hot_sync <= {hot_sync[1:0], over_temperature_cutoff};
    end
  end

  // Filtered levels change only once stages 1 and 2 agree
  wire next_sck   = filter_next(sck_sync, sck_level);
  wire next_sdata = filter_next(sdata_sync, sdata_level);
  wire next_latch = filter_next(latch_sync, latch_level);
  wire next_rstn  = filter_next(rstn_sync, rstn_level);
  wire next_dis   = filter_next(dis_sync, dis_level);
  wire next_hot   = filter_next(hot_sync, hot_level);

  wire sck_rise   = went_high(sck_level, next_sck);
  wire sck_fall   = ~next_sck & sck_level;
  wire latch_rise = went_high(latch_level, next_latch);
  wire clear      = ~rstn_level;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_level <= 1'h0;
    end else begin
      sck_level <= next_sck;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdata_level <= 1'h0;
    end else begin
      sdata_level <= next_sdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_level <= 1'h0;
    end else begin
      latch_level <= next_latch;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstn_level <= 1'h0;
    end else begin
      rstn_level <= next_rstn;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dis_level <= 1'h1;
    end else begin
      dis_level <= next_dis;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hot_level <= 1'h0;
    end else begin
      hot_level <= next_hot;
    end
  end

  // Serial data enters the low end, oldest bit sits at the top
  wire [WIDTH-1:0] next_shift = {shift_reg[WIDTH-2:0], sdata_level};

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      shift_reg <= '0;
    end else if (sck_rise) begin
      shift_reg <= next_shift;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      hold_reg <= '0;
    end else if (latch_rise) begin
      hold_reg <= shift_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      cascade_bit <= 1'h0;
    end else if (sck_fall) begin
      cascade_bit <= shift_reg[WIDTH-1];
    end
  end

  // Cutoff only counts while outputs are enabled
  wire thermal_off = hot_level & ~dis_level;
  wire [WIDTH-1:0] next_on = (clear | dis_level | thermal_off) ? '0 : hold_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_outputs_oe <= {WIDTH{sls_pkg::OE_RELEASE}};
    end else begin
      drive_outputs_oe <= ~next_on;
    end
  end

  assign drive_outputs         = '0;
  assign holding_state         = hold_reg;
  assign link.cascade_data_out = cascade_bit;
endmodule

// ===== rtl/sls_host.sv
// Host end: frames words onto the three-wire link with documented timing
`timescale 1ns/1ps
module sls_host #(
  parameter int FRAME_BITS = sls_pkg::CHANNELS
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  sls_link_if.host                   link,
  input  wire logic                  start,
  input  wire logic [FRAME_BITS-1:0] frame_data,
  input  wire logic                  device_enable,
  input  wire logic                  output_disable,
  output logic                       busy,
  output logic                       done
);
  typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_GAP, S_LATCH} sls_host_state_type;
  sls_host_state_type state;
  logic [FRAME_BITS-1:0]     data;
  logic [sls_pkg::BITS_W-1:0] bits;
  logic [sls_pkg::CNT_W-1:0]  cnt;
  logic sck;
  logic sdata;
  logic latch;
  logic rstn;
  logic dis;

  localparam logic [sls_pkg::CNT_W-1:0] HALF = sls_pkg::CNT_W'(sls_pkg::SCK_HALF_CYC - 1);
  localparam logic [sls_pkg::CNT_W-1:0] GAP  = sls_pkg::CNT_W'(sls_pkg::LATCH_DELAY_CYC - 1);
  localparam logic [sls_pkg::CNT_W-1:0] LHI  = sls_pkg::CNT_W'(sls_pkg::LATCH_HIGH_CYC - 1);

  wire cnt_done = (cnt == '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      data  <= '0;
      bits  <= '0;
      cnt   <= '0;
      sck   <= 1'b0;
      sdata <= 1'b0;
      latch <= 1'b0;
      rstn  <= 1'b0;
      dis   <= 1'b1;
      done  <= 1'b0;
    end else begin
      rstn <= device_enable;
      dis  <= output_disable;
      done <= 1'b0;
      if (!cnt_done)
        cnt <= cnt - 1'b1;
      unique case (state)
        S_IDLE: begin
          if (start) begin
            data  <= frame_data;
            bits  <= sls_pkg::BITS_W'(FRAME_BITS);
            sdata <= frame_data[FRAME_BITS-1];
            cnt   <= HALF;
            state <= S_LOW;
          end
        end
        S_LOW: begin
          if (cnt_done) begin
            sck   <= 1'b1;
            cnt   <= HALF;
            data  <= {data[FRAME_BITS-2:0], 1'b0};
            bits  <= bits - 1'b1;
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (cnt_done) begin
            sck <= 1'b0;
            cnt <= HALF;
            if (bits == '0) begin
              cnt   <= GAP;
              state <= S_GAP;
            end else begin
              sdata <= data[FRAME_BITS-1];
              state <= S_LOW;
            end
          end
        end
        S_GAP: begin
          if (cnt_done) begin
            latch <= 1'b1;
            cnt   <= LHI;
            state <= S_LATCH;
          end
        end
        S_LATCH: begin
          if (cnt_done) begin
            latch <= 1'b0;
            done  <= 1'b1;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  assign busy                = (state != S_IDLE);
  assign link.sck            = sck;
  assign link.sdata          = sdata;
  assign link.latch          = latch;
  assign link.reset_n        = rstn;
  assign link.output_disable = dis;
endmodule

// ===== tb/sls_link_chk.sv
// Concurrent checks on the host to switch link
`timescale 1ns/1ps
module sls_link_chk #(
  parameter int FRAME_BITS = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic sdata,
  input wire logic latch,
  input wire logic reset_n,
  input wire logic output_disable,
  input wire logic cascade_data_out
);
  logic [7:0] run;
  logic [7:0] n_rise;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Cycles since the link clock last changed
  always_ff @(posedge clk) begin
    if (sys_rst || $changed(sck)) run <= 8'h00;
    else if (run != 8'hff) run <= run + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || latch) n_rise <= 8'h00;
    else if ($rose(sck)) n_rise <= n_rise + 8'h01;
  end
  a_sck_phase_width: assert property ($changed(sck) |-> run >= sls_pkg::SCK_HALF_CYC - 1)
    else $error("clock phase too short");
  a_data_steady: assert property ($changed(sdata) |-> !sck)
    else $error("data moved while clock high");
  a_latch_width: assert property ($rose(latch) |-> latch throughout (##59 1'b1))
    else $error("latch pulse too short");
  a_latch_delay: assert property ($rose(latch) |-> !sck && run >= sls_pkg::LATCH_DELAY_CYC - 1)
    else $error("latch too soon after clock");
  a_frame_count: assert property ($rose(latch) |-> n_rise == FRAME_BITS)
    else $error("wrong clock count in frame");
  a_cascade_on_fall: assert property ($changed(cascade_data_out) |-> !sck)
    else $error("cascade moved while clock high");
  a_reset_clears_cascade: assert property (!reset_n [*8] |-> !cascade_data_out)
    else $error("cascade not cleared by reset");
  a_power_up_hold: assert property ($fell(sys_rst) |-> !reset_n)
    else $error("device reset released at power up");
  cover property ($rose(latch));
  cover property ($rose(output_disable));
  cover property ($fell(reset_n));
endmodule

// ===== tb/tb_top.sv
// Self-checking bench: host driving two chained switches
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        sys_rst;
  logic        start;
  logic [23:0] frame_data;
  logic        device_enable;
  logic        output_disable;
  logic        hot;
  logic        busy;
  logic        done;
  logic [11:0] oe0;
  logic [11:0] oe1;
  logic [11:0] pin0;
  logic [11:0] hold0;
  logic [11:0] hold1;
  int          fail_count;
  int          samples_checked;
  int          cycles;
  sls_link_if link0 ();
  sls_link_if link1 ();
  // Downstream switch shares clock and latch, takes upstream cascade
  assign link1.sck = link0.sck;
  assign link1.sdata = link0.cascade_data_out;
  assign link1.latch = link0.latch;
  assign link1.reset_n = link0.reset_n;
  assign link1.output_disable = link0.output_disable;
  sls_host #(.FRAME_BITS(24)) sls_host_inst (.clk(clk), .sys_rst(sys_rst), .link(link0), .start(start),
    .frame_data(frame_data), .device_enable(device_enable), .output_disable(output_disable), .busy(busy), .done(done));
  sls_device sls_device_inst (.clk(clk), .sys_rst(sys_rst), .link(link0), .over_temperature_cutoff(hot),
    .drive_outputs_oe(oe0), .drive_outputs(pin0), .holding_state(hold0));
  sls_device sls_device_inst_b (.clk(clk), .sys_rst(sys_rst), .link(link1), .over_temperature_cutoff(1'b0),
    .drive_outputs_oe(oe1), .drive_outputs(), .holding_state(hold1));
  sls_link_chk #(.FRAME_BITS(24)) sls_link_chk_inst (.clk(clk), .sys_rst(sys_rst), .sck(link0.sck),
    .sdata(link0.sdata), .latch(link0.latch), .reset_n(link0.reset_n), .output_disable(link0.output_disable),
    .cascade_data_out(link0.cascade_data_out));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_chain(input logic [23:0] word, input logic [11:0] prev);
    int n;
    n = 0;
    start = 1'b1;
    frame_data = word;
    tick(1);
    start = 1'b0;
    check(busy, 1'b1);
    tick(1500);
    check(hold0, prev);
    while (done !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check(done, 1'b1);
    check(busy, 1'b0);
    tick(10);
    check(hold1, word[23:12]);
    check(hold0, word[11:0]);
    check(oe0, 12'(~word[11:0]));
    check(oe1, 12'(~word[23:12]));
    check(link1.cascade_data_out, word[23]);
    check(link0.cascade_data_out, word[11]);
    check(pin0, 12'h000);
  endtask
  task automatic t_disable(input logic [11:0] held);
    for (int i = 0; i < 4; i++) begin
      output_disable = ~i[0];
      tick(10);
      check(oe0, output_disable ? 12'hfff : 12'(~held));
    end
  endtask
  task automatic t_thermal(input logic [11:0] held);
    hot = 1'b1;
    tick(10);
    check(oe0, 12'hfff);
    hot = 1'b0;
    tick(10);
    check(oe0, 12'(~held));
  endtask
  task automatic t_reset;
    device_enable = 1'b0;
    tick(12);
    check(hold0, 12'h000);
    check(hold1, 12'h000);
    check(oe1, 12'hfff);
    check(oe0, 12'hfff);
    check(link1.cascade_data_out, 1'b0);
    device_enable = 1'b1;
    tick(10);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    {start, frame_data, output_disable, hot, fail_count, samples_checked, cycles} = '0;
    sys_rst = 1'b1;
    device_enable = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(10);
    t_chain(24'ha5c3e1, 12'h000);
    t_chain(24'h5a3c1e, 12'h3e1);
    t_disable(12'hc1e);
    t_thermal(12'hc1e);
    t_reset;
    t_chain(24'hfff000, 12'h000);
    stop_test;
  end
endmodule
